// ==== core/wdr_pkg.sv ====
/*
 * wdr_pkg: constants shared by the watchdog and reset-cause block.
 * Assumes a 10 MHz core clock and 32-bit Avalon-MM register access.
 */
`default_nettype none

package wdr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // clock and timing
   localparam int CLK_HZ = 10_000_000;
   localparam int CLK_NS = 100;
   localparam int WDT_OSC_HZ = 1_000_000;
   localparam int WDT_DIV = CLK_HZ / WDT_OSC_HZ;
   localparam int T_BOD_NS = 2000;
   localparam int BOD_CYC = (T_BOD_NS + CLK_NS - 1) / CLK_NS;
   localparam int T_RST_NS = 1500;
   localparam int PIN_CYC = T_RST_NS / CLK_NS;
   localparam int WDTOE_HOLD = 4;
   localparam int STARTUP_CYC_DEF = 1024;

   ////////////////////////////////////////////////////////////////////////////
   // register map (byte addresses)
   localparam logic [3:0] ADDR_CAUSE = 4'h0;
   localparam logic [3:0] ADDR_WDT_CTRL = 4'h4;

   // reset cause fields
   localparam int CAUSE_SCAN = 4;
   localparam int CAUSE_WDT = 3;
   localparam int CAUSE_BOD = 2;
   localparam int CAUSE_PIN = 1;
   localparam int CAUSE_POR = 0;
   localparam logic [4:0] CAUSE_RST = 5'h01;

   // watchdog control fields
   localparam int CTRL_OE = 4;
   localparam int CTRL_EN = 3;
   localparam int CTRL_PS_HI = 2;
   localparam logic [2:0] CTRL_PS_RST = 3'h0;

   // watchdog period: base count doubled per select step
   localparam logic [21:0] WDT_BASE = 22'h004000;

   // synchroniser lanes
   localparam int SYN_W = 5;
   localparam int SYN_PIN = 0;
   localparam int SYN_LOW = 1;
   localparam int SYN_SCAN = 2;
   localparam int SYN_BEN = 3;
   localparam int SYN_BLV = 4;
   localparam logic [SYN_W-1:0] SYN_RST = 5'h01;

   typedef logic [21:0] wdr_count_t;

endpackage : wdr_pkg

`default_nettype wire

// ==== core/wdr_top.sv ====
/*
 * wdr_top: watchdog timer, reset sequencing and reset-cause flags.
 * Assumes pin, supply monitor, scan reset and fuses arrive unsynchronised;
 * comparator select, converter enable and restart come from core logic.
 */
// Implementation choices: the register offsets and the Avalon-MM slave port.
// How it works
// - pin low forces reset, even clock stopped
// - after pin release, hold for delay
// - fuse picks 2.7V or 4.0V trip
// - enabled brown-out resets, releases after delay
// - ignore supply dips shorter than filter
// - watchdog timeout gives one-cycle pulse
// - delay counts from falling pulse edge
// - bit 4 flags scan reset
// - bit 3 flags watchdog reset
// - bit 2 flags brown-out reset
// - bit 1 flags pin reset
// - bit 0 power flag, software clears only
// - reference on for detector, comparator, converter
// - watchdog counts own 1 MHz tick
// - restart, disable, chip reset clear counter
// - unrestarted timeout resets the chip
// - control bits 7..5 read zero
// - turn-off enable self-clears after four cycles
// - enable clears only with turn-off enable
// - select gives 16K doubling to 2048K
`timescale 1ns/1ps
`default_nettype none

module wdr_top #(
   parameter int P_STARTUP_CYC = wdr_pkg::STARTUP_CYC_DEF,
   parameter wdr_pkg::wdr_count_t P_WDT_BASE = wdr_pkg::WDT_BASE
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_reset_pin_n,
   input wire logic i_supply_low,
   input wire logic i_scan_reset,
   input wire logic i_brownout_enable_fuse,
   input wire logic i_brownout_level_fuse,
   input wire logic i_comparator_bandgap_select,
   input wire logic i_converter_enable,
   input wire logic i_wdt_restart,
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output logic o_chip_reset,
   output logic o_wdt_pulse,
   output logic o_ref_enable,
   output logic o_bod_level_high
);
   import wdr_pkg::*;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);

   function automatic wdr_count_t wdt_period(input logic [2:0] sel);
      wdt_period = P_WDT_BASE << sel;
   endfunction : wdt_period

   ////////////////////////////////////////////////////////////////////////////
   // input synchronisers
   logic [SYN_W-1:0] syn1_reg;
   logic [SYN_W-1:0] syn2_reg;

   generate
      for (genvar g = 0; g < SYN_W; g++) begin : g_sync
         always_ff @(posedge i_clk or posedge i_sys_rst) begin
            if (i_sys_rst) begin
               syn1_reg[g] <= SYN_RST[g];
               syn2_reg[g] <= SYN_RST[g];
            end else begin
               syn1_reg[g] <= (g == SYN_PIN) ? i_reset_pin_n :
                              (g == SYN_LOW) ? i_supply_low :
                              (g == SYN_SCAN) ? i_scan_reset :
                              (g == SYN_BEN) ? i_brownout_enable_fuse :
                              i_brownout_level_fuse;
               syn2_reg[g] <= syn1_reg[g];
            end
         end
      end
   endgenerate

   logic pin_low_s;
   logic bod_en_s;
   assign pin_low_s = !syn2_reg[SYN_PIN];
   assign bod_en_s = syn2_reg[SYN_BEN];

   ////////////////////////////////////////////////////////////////////////////
   // pin and brown-out filters
   logic [7:0] pin_cnt_reg;
   logic [7:0] bod_cnt_reg;
   logic pin_trip_reg;
   logic bod_trip_reg;

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pin_cnt_reg <= 8'h00;
         pin_trip_reg <= 1'b0;
      end else if (!pin_low_s) begin
         pin_cnt_reg <= 8'h00;
         pin_trip_reg <= 1'b0;
      end else if (pin_cnt_reg < 8'(PIN_CYC)) begin
         pin_cnt_reg <= pin_cnt_reg + 8'h01;
      end else begin
         pin_trip_reg <= 1'b1;
      end
   end

   // short dips never reach the count, so they never trip
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         bod_cnt_reg <= 8'h00;
         bod_trip_reg <= 1'b0;
      end else if (!syn2_reg[SYN_LOW] || !bod_en_s) begin
         bod_cnt_reg <= 8'h00;
         bod_trip_reg <= 1'b0;
      end else if (bod_cnt_reg < 8'(BOD_CYC)) begin
         bod_cnt_reg <= bod_cnt_reg + 8'h01;
      end else begin
         bod_trip_reg <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // reset sequencer
   logic [15:0] delay_cnt_reg;
   logic src_active;
   assign src_active = pin_low_s | bod_trip_reg | syn2_reg[SYN_SCAN] | o_wdt_pulse;

   // pin low acts asynchronously so a stopped clock still resets
   always_ff @(posedge i_clk or posedge i_sys_rst or negedge i_reset_pin_n) begin
      if (i_sys_rst) begin
         o_chip_reset <= 1'b1;
         delay_cnt_reg <= 16'h0000;
      end else if (!i_reset_pin_n) begin
         o_chip_reset <= 1'b1;
         delay_cnt_reg <= 16'h0000;
      end else if (src_active) begin
         o_chip_reset <= 1'b1;
         delay_cnt_reg <= 16'h0000;
      end else if (o_chip_reset) begin
         if (delay_cnt_reg == 16'(P_STARTUP_CYC - 1)) begin
            o_chip_reset <= 1'b0;
         end else begin
            delay_cnt_reg <= delay_cnt_reg + 16'h0001;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_ref_enable <= 1'b0;
         o_bod_level_high <= 1'b0;
      end else begin
         o_ref_enable <= bod_en_s | i_comparator_bandgap_select | i_converter_enable;
         o_bod_level_high <= syn2_reg[SYN_BLV];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register bus
   logic wait_reg;
   logic wr_acc;
   logic wr_cause;
   logic wr_ctrl;
   logic [7:0] wd;
   logic [4:0] cause_reg;
   logic wdtoe_reg;
   logic wde_reg;
   logic [2:0] wdp_reg;
   logic [2:0] oe_cnt_reg;

   assign wr_acc = i_avs_write && !wait_reg && i_avs_byteenable[0];
   assign wr_cause = wr_acc && (i_avs_address == ADDR_CAUSE);
   assign wr_ctrl = wr_acc && (i_avs_address == ADDR_WDT_CTRL);
   assign wd = i_avs_writedata[7:0];
   assign o_avs_waitrequest = wait_reg;

   // one wait cycle per access keeps read data registered
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wait_reg <= 1'b1;
         o_avs_readdata <= 32'h00000000;
      end else if ((i_avs_read || i_avs_write) && wait_reg) begin
         wait_reg <= 1'b0;
         case (i_avs_address)
            ADDR_CAUSE: begin
               o_avs_readdata <= {27'h0000000, cause_reg};
            end
            ADDR_WDT_CTRL: begin
               o_avs_readdata <= {27'h0000000, wdtoe_reg, wde_reg, wdp_reg};
            end
            default: begin
               o_avs_readdata <= 32'h00000000;
            end
         endcase
      end else begin
         wait_reg <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // reset-cause flags: a set in the clearing cycle wins
   logic [4:0] cause_set;
   assign cause_set = {syn2_reg[SYN_SCAN], o_wdt_pulse, bod_trip_reg, pin_trip_reg, 1'b0};

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cause_reg <= CAUSE_RST;
      end else begin
         cause_reg <= cause_set | (wr_cause ? (cause_reg & wd[4:0]) : cause_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // watchdog control
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wde_reg <= 1'b0;
         wdp_reg <= CTRL_PS_RST;
      end else if (wr_ctrl) begin
         wdp_reg <= wd[CTRL_PS_HI:0];
         if (wd[CTRL_EN]) begin
            wde_reg <= 1'b1;
         end else if (wdtoe_reg) begin
            wde_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wdtoe_reg <= 1'b0;
         oe_cnt_reg <= 3'h0;
      end else if (wr_ctrl) begin
         wdtoe_reg <= wd[CTRL_OE];
         oe_cnt_reg <= wd[CTRL_OE] ? 3'(WDTOE_HOLD) : 3'h0;
      end else if (oe_cnt_reg != 3'h0) begin
         oe_cnt_reg <= oe_cnt_reg - 3'h1;
         if (oe_cnt_reg == 3'h1) begin
            wdtoe_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // watchdog oscillator tick and counter
   logic [3:0] div_reg;
   logic tick;
   logic restart_pend_reg;
   wdr_count_t wdt_cnt_reg;
   assign tick = (div_reg == 4'(WDT_DIV - 1));

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         div_reg <= 4'h0;
      end else begin
         div_reg <= tick ? 4'h0 : div_reg + 4'h1;
      end
   end

   // restart waits for the next tick, as a slow oscillator would see it
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         restart_pend_reg <= 1'b0;
      end else if (i_wdt_restart) begin
         restart_pend_reg <= 1'b1;
      end else if (tick) begin
         restart_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wdt_cnt_reg <= 22'h000000;
         o_wdt_pulse <= 1'b0;
      end else begin
         o_wdt_pulse <= 1'b0;
         if (o_chip_reset || !wde_reg) begin
            wdt_cnt_reg <= 22'h000000;
         end else if (tick) begin
            if (restart_pend_reg) begin
               wdt_cnt_reg <= 22'h000000;
            end else if (wdt_cnt_reg >= wdt_period(wdp_reg) - 22'h000001) begin
               wdt_cnt_reg <= 22'h000000;
               o_wdt_pulse <= 1'b1;
            end else begin
               wdt_cnt_reg <= wdt_cnt_reg + 22'h000001;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_pulse_one_cycle: assert property (o_wdt_pulse |=> !o_wdt_pulse)
      else $error("watchdog pulse longer than one cycle");
   a_pulse_holds_reset: assert property (o_wdt_pulse |=> o_chip_reset [*2])
      else $error("reset not held after watchdog pulse");
   a_release_after_delay: assert property (
      $fell(o_chip_reset) |-> $past(delay_cnt_reg) == 16'(P_STARTUP_CYC - 1))
      else $error("reset released before delay");
   a_bod_filter_len: assert property (
      $rose(bod_trip_reg) |-> $past(bod_cnt_reg) == 8'(BOD_CYC))
      else $error("brown-out tripped early");
   a_oe_self_clear: assert property (
      (wr_ctrl && wd[CTRL_OE]) ##1 !wr_ctrl [*4] |-> wdtoe_reg ##1 !wdtoe_reg)
      else $error("turn-off enable timing wrong");
   a_en_protected: assert property (
      (wr_ctrl && !wd[CTRL_EN] && !wdtoe_reg && wde_reg) |=> wde_reg)
      else $error("watchdog disabled without turn-off enable");
   a_en_set: assert property ((wr_ctrl && wd[CTRL_EN]) |=> wde_reg)
      else $error("watchdog enable not set");
   a_wdt_flag_set: assert property (o_wdt_pulse |=> cause_reg[CAUSE_WDT])
      else $error("watchdog flag not set");
   a_por_flag_kept: assert property (
      $fell(cause_reg[CAUSE_POR]) |-> $past(wr_cause && !wd[CAUSE_POR]))
      else $error("power flag cleared without write");
   a_cnt_clear_rst: assert property (o_chip_reset |=> wdt_cnt_reg == 22'h000000)
      else $error("watchdog counter runs during reset");
   a_ref_follows: assert property (i_converter_enable |=> o_ref_enable)
      else $error("reference off while converter enabled");
   a_bod_resets: assert property (bod_trip_reg |=> o_chip_reset)
      else $error("brown-out did not reset");

   c_wdt_timeout: cover property (o_wdt_pulse);
   c_wdt_disable: cover property ($fell(wde_reg));
   c_bod_trip: cover property ($rose(bod_trip_reg));
   c_pin_flag: cover property ($rose(cause_reg[CAUSE_PIN]));

endmodule : wdr_top

`default_nettype wire

// ==== tb/wdr_far_side.sv ====
/*
 * wdr_far_side: model of the reset pin driver and the supply monitor.
 * Assumes the bench calls its tasks from the core clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module wdr_far_side (
   input wire logic i_clk,
   output logic o_reset_pin_n,
   output logic o_supply_low
);

   // pin sits on its pull-up, supply good, until a task says otherwise
   initial begin
      o_reset_pin_n = 1'b1;
      o_supply_low = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin held low for n cycles, then back to the pull-up level
   task automatic pin_low(input int n);
      @(posedge i_clk);
      o_reset_pin_n <= 1'b0;
      repeat (n) @(posedge i_clk);
      o_reset_pin_n <= 1'b1;
   endtask : pin_low

   // supply below trip level for n cycles
   task automatic supply_dip(input int n);
      @(posedge i_clk);
      o_supply_low <= 1'b1;
      repeat (n) @(posedge i_clk);
      o_supply_low <= 1'b0;
   endtask : supply_dip

endmodule : wdr_far_side

`default_nettype wire

// ==== tb/tb.sv ====
/*
 * tb: self-checking bench for wdr_top, bus tasks and reset scenarios.
 * Assumes a 10 MHz clock; startup delay and watchdog base shortened to 16.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin error_cnt++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, ex, gt); end end

module tb;
   import wdr_pkg::*;
   localparam int STUP = 16;
   // short watchdog base so a timeout fits the run
   localparam int WB = 16;
   logic clk = 1'b0, rst = 1'b1, scan = 1'b0, ben = 1'b0, blv = 1'b0, bg = 1'b0;
   logic conv = 1'b0, rstrt = 1'b0, rd = 1'b0, wr = 1'b0;
   logic [3:0] addr = 4'h0, be = 4'hF;
   logic [31:0] wdata = 32'h0, rdata;
   logic wait_req, chip_rst, wdt_pulse, ref_en, lvl_hi, pin_n, sup_low;
   logic [7:0] got, ctrl_exp, d;
   integer seed = 32'h590CDDD2;
   int error_cnt = 0, total_checks = 0, cyc = 0, hits;

   wdr_top #(.P_STARTUP_CYC(STUP), .P_WDT_BASE(22'(WB))) uut (.i_clk(clk), .i_sys_rst(rst),
      .i_reset_pin_n(pin_n), .i_supply_low(sup_low), .i_scan_reset(scan),
      .i_brownout_enable_fuse(ben),
      .i_brownout_level_fuse(blv), .i_comparator_bandgap_select(bg),
      .i_converter_enable(conv), .i_wdt_restart(rstrt), .i_avs_address(addr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
      .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req), .o_chip_reset(chip_rst),
      .o_wdt_pulse(wdt_pulse), .o_ref_enable(ref_en), .o_bod_level_high(lvl_hi));
   wdr_far_side far (.i_clk(clk), .o_reset_pin_n(pin_n), .o_supply_low(sup_low));

   initial begin
      forever #50 clk = ~clk;
   end

   // hang guard: the whole run needs under two thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         wrap_up();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] dv,
                      input logic [3:0] bv);
      @(posedge clk);
      addr <= a;
      wdata <= {24'h0, dv};
      be <= bv;
      wr <= w;
      rd <= !w;
      // no local limit: the hang guard ends a stuck wait
      do begin
         @(posedge clk);
      end while (wait_req !== 1'b0);
      got = rdata[7:0];
      wr <= 1'b0;
      rd <= 1'b0;
   endtask : bus

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] ex);
      bus(1'b0, a, 8'h00, 4'hF);
      `CHK("readdata", ex, got)
      `CHK("read_hi", 24'h000000, rdata[31:8])
   endtask : rd_chk

   // chip reset must stay quiet for n cycles
   task automatic quiet(input int n);
      hits = 0;
      repeat (n) begin
         @(negedge clk);
         if (chip_rst !== 1'b0) hits++;
      end
      `CHK("quiet", 0, hits)
   endtask : quiet

   // release comes no earlier than four cycles short of the startup delay, and within 40 cycles after that
   task automatic release_chk();
      repeat (STUP - 4) @(negedge clk);
      `CHK("held", 1'b1, chip_rst)
      hits = 0;
      while (chip_rst !== 1'b0 && hits < 40) begin
         @(negedge clk);
         hits++;
      end
      `CHK("released", 1'b0, chip_rst)
   endtask : release_chk

   function automatic logic [7:0] ctrl_next(input logic [7:0] old, input logic [7:0] dv);
      return {4'h0, dv[3] | old[3], dv[2:0]};
   endfunction : ctrl_next

   task automatic wrap_up();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : wrap_up

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      release_chk();
      rd_chk(ADDR_CAUSE, 8'h01);
      rd_chk(ADDR_WDT_CTRL, 8'h00);
      // reference enable over all three sources, level fuse alongside
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         ben <= i[0];
         bg <= i[1];
         conv <= i[2];
         blv <= i[1];
         repeat (6) @(negedge clk);
         `CHK("ref_en", i[0] | i[1] | i[2], ref_en)
         `CHK("level", i[1], lvl_hi)
      end
      // control register: random writes without turn-off enable
      ctrl_exp = 8'h00;
      repeat (12) begin
         d = 8'($random(seed));
         d[4] = 1'b0;
         bus(1'b1, ADDR_WDT_CTRL, d, 4'hF);
         ctrl_exp = ctrl_next(ctrl_exp, d);
         rstrt <= 1'b1;
         @(posedge clk) rstrt <= 1'b0;
         rd_chk(ADDR_WDT_CTRL, ctrl_exp);
      end
      bus(1'b1, ADDR_WDT_CTRL, 8'h08, 4'hF);
      bus(1'b1, ADDR_WDT_CTRL, 8'h00, 4'hF);
      rd_chk(ADDR_WDT_CTRL, 8'h08);
      bus(1'b1, ADDR_WDT_CTRL, 8'h07, 4'h0);
      rd_chk(ADDR_WDT_CTRL, 8'h08);
      bus(1'b1, ADDR_WDT_CTRL, 8'hFF, 4'hF);
      rd_chk(ADDR_WDT_CTRL, 8'h1F);
      repeat (4) @(posedge clk);
      rd_chk(ADDR_WDT_CTRL, 8'h0F);
      bus(1'b1, ADDR_WDT_CTRL, 8'h18, 4'hF);
      bus(1'b1, ADDR_WDT_CTRL, 8'h00, 4'hF);
      rd_chk(ADDR_WDT_CTRL, 8'h00);
      // unmapped place
      bus(1'b1, 4'h8, 8'hFF, 4'hF);
      rd_chk(4'h8, 8'h00);
      rd_chk(4'hC, 8'h00);
      // pin reset
      fork
         far.pin_low(30);
         begin
            repeat (2) @(negedge clk);
            `CHK("pin_rst", 1'b1, chip_rst)
         end
      join
      release_chk();
      rd_chk(ADDR_CAUSE, 8'h03);
      bus(1'b1, ADDR_CAUSE, 8'h1D, 4'hF);
      rd_chk(ADDR_CAUSE, 8'h01);
      bus(1'b1, ADDR_CAUSE, 8'h1E, 4'hF);
      rd_chk(ADDR_CAUSE, 8'h00);
      // brown-out: short dip, long dip, long dip with detector off
      @(posedge clk) ben <= 1'b1;
      repeat (4) @(posedge clk);
      fork
         far.supply_dip(10);
         quiet(40);
      join
      far.supply_dip(40);
      release_chk();
      rd_chk(ADDR_CAUSE, 8'h04);
      bus(1'b1, ADDR_CAUSE, 8'h00, 4'hF);
      rd_chk(ADDR_CAUSE, 8'h00);
      @(posedge clk) ben <= 1'b0;
      repeat (4) @(posedge clk);
      fork
         far.supply_dip(40);
         quiet(60);
      join
      // scan-chain reset
      @(posedge clk) scan <= 1'b1;
      repeat (6) @(posedge clk);
      `CHK("scan_rst", 1'b1, chip_rst)
      scan <= 1'b0;
      release_chk();
      rd_chk(ADDR_CAUSE, 8'h10);
      // watchdog: timeout at select 0, restarts hold it off, then disable
      bus(1'b1, ADDR_CAUSE, 8'h00, 4'hF);
      bus(1'b1, ADDR_WDT_CTRL, 8'h08, 4'hF);
      hits = 0;
      while (wdt_pulse !== 1'b1 && hits < 400) begin
         @(negedge clk);
         hits++;
      end
      `CHK("wdt_timeout", 1'b1, wdt_pulse)
      `CHK("wdt_period", 1'b1, hits > (WB - 1) * WDT_DIV && hits <= WB * WDT_DIV)
      @(negedge clk);
      `CHK("pulse_len", 1'b0, wdt_pulse)
      `CHK("wdt_rst", 1'b1, chip_rst)
      release_chk();
      rd_chk(ADDR_CAUSE, 8'h08);
      fork
         quiet(400);
         repeat (10) begin
            repeat (40) @(posedge clk);
            rstrt <= 1'b1;
            @(posedge clk) rstrt <= 1'b0;
         end
      join
      bus(1'b1, ADDR_WDT_CTRL, 8'h18, 4'hF);
      bus(1'b1, ADDR_WDT_CTRL, 8'h00, 4'hF);
      quiet(300);
      rd_chk(ADDR_CAUSE, 8'h08);
      `CHK("wdt_pulse", 1'b0, wdt_pulse)
      wrap_up();
   end
endmodule : tb

`default_nettype wire
